// ===== core/branch_inc_or_exec.sv
// Purpose: decode and execute jump, increment, increment-skip and OR instructions
// Assumes: fileData is the read value of the register addressed by instr[4:0], same cycle
// Notes: other opcodes execute as no-operation here; the program counter advances by one
//
// Summary of operation
// - opcode top bits 101 is an always-taken jump lasting two cycles with no flag change.
// - the jump loads its 9-bit immediate into counter bits 8..0 and page bits into 11..9.
// - opcode 0010 10 adds one to the file register and updates carry, digit carry and zero.
// - destination bit 0 sends the result to the accumulator, 1 back to the file register.
// - opcode 0011 11 increments the file register per destination and leaves flags alone.
// - a zero increment-skip result discards the prefetched instruction and runs a no-op.
// - opcode 1101 ORs the 8-bit literal into the accumulator, touching only the zero flag.
`timescale 1ns/100ps
module branch_inc_or_exec (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] instr,
  input wire logic [7:0] fileData,
  input wire logic [7:0] statusIn,
  output logic [4:0] fileAddr,
  output logic [7:0] fileWrData,
  output logic fileWrEn,
  output logic [7:0] accumulator,
  output logic [7:0] statusOut,
  output logic statusWrEn,
  output logic [11:0] program_counter,
  output logic flushFetch
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  typedef enum logic [1:0] {EXEC, FLUSH} phase_e;
  phase_e phase;

  logic [7:0] literal;
  logic destFile;
  logic isJump;
  logic isInc;
  logic isIncSkip;
  logic isOrReg;
  logic isOrLit;
  logic [8:0] incSum;
  logic [4:0] lowSum;
  logic [7:0] orReg;
  logic [7:0] orLit;
  logic [7:0] next_status;

  // 8-bit zero test, used for several flag and skip decisions
  function automatic logic isZero(input logic [7:0] v);
    return v == branch_inc_or_pkg::ZERO_DATA;
  endfunction

  assign literal = instr[7:0];
  assign destFile = instr[branch_inc_or_pkg::DEST_BIT];
  assign isJump = instr[11:9] == branch_inc_or_pkg::OP_JUMP;
  assign isInc = instr[11:6] == branch_inc_or_pkg::OP_INC;
  assign isIncSkip = instr[11:6] == branch_inc_or_pkg::OP_INC_SKIP;
  assign isOrReg = instr[11:6] == branch_inc_or_pkg::OP_OR_REG;
  assign isOrLit = instr[11:8] == branch_inc_or_pkg::OP_OR_LIT;

  // datapath results; digit carry comes from the low nibble sum
  assign incSum = {1'b0, fileData} + {1'b0, branch_inc_or_pkg::ONE};
  assign lowSum = {1'b0, fileData[3:0]} + 5'h01;
  assign orReg = accumulator | fileData;
  assign orLit = accumulator | literal;

  // flag update, built from the incoming status so untouched bits keep their value
  always_comb begin
    next_status = statusIn;
    if (isInc) begin
      next_status[branch_inc_or_pkg::ST_CARRY] = incSum[8];
      next_status[branch_inc_or_pkg::ST_DIGIT] = lowSum[4];
      next_status[branch_inc_or_pkg::ST_ZERO] = isZero(incSum[7:0]);
    end else if (isOrReg) begin
      next_status[branch_inc_or_pkg::ST_ZERO] = isZero(orReg);
    end else if (isOrLit) begin
      next_status[branch_inc_or_pkg::ST_ZERO] = isZero(orLit);
    end
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // flush phase turns the already-fetched word into a no-op cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= EXEC;
    end else begin
      case (phase)
        EXEC: begin
          if (isJump) begin
            phase <= FLUSH;
          end else if (isIncSkip && isZero(incSum[7:0])) begin
            phase <= FLUSH;
          end
        end
        FLUSH: phase <= EXEC;
        default: phase <= EXEC;
      endcase
    end
  end

  // flush pulse tells fetch to drop its prefetched word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flushFetch <= 1'b0;
    end else begin
      flushFetch <= phase == EXEC && (isJump || (isIncSkip && isZero(incSum[7:0])));
    end
  end

  // program counter; the flush cycle still advances past the discarded word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      program_counter <= branch_inc_or_pkg::COUNTER_RESET;
    end else if (phase == EXEC && isJump) begin
      program_counter <= {statusIn[branch_inc_or_pkg::ST_PAGE_HI:branch_inc_or_pkg::ST_PAGE_LO],
                          instr[8:0]};
    end else begin
      program_counter <= program_counter + 12'h001;
    end
  end

  // ----------------------------------------
  // writeback
  // ----------------------------------------
  // accumulator is only touched in an execute phase, never during a flush
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator <= branch_inc_or_pkg::ZERO_DATA;
    end else if (phase == EXEC) begin
      if (isOrLit) begin
        accumulator <= orLit;
      end else if ((isInc || isIncSkip) && !destFile) begin
        accumulator <= incSum[7:0];
      end else if (isOrReg && !destFile) begin
        accumulator <= orReg;
      end
    end
  end

  // file write strobe with data; address follows the instruction
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fileWrEn <= 1'b0;
      fileWrData <= branch_inc_or_pkg::ZERO_DATA;
      fileAddr <= 5'h00;
    end else begin
      fileWrEn <= phase == EXEC && destFile && (isInc || isIncSkip || isOrReg);
      fileWrData <= isOrReg ? orReg : incSum[7:0];
      fileAddr <= instr[4:0];
    end
  end

  // status writes; jump and increment-skip never assert the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      statusWrEn <= 1'b0;
      statusOut <= branch_inc_or_pkg::ZERO_DATA;
    end else begin
      // no flag change on skip form
      statusWrEn <= phase == EXEC && (isInc || isOrReg || isOrLit);
      statusOut <= next_status;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  jump_two_cycles_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && isJump |=> phase == FLUSH && flushFetch && !statusWrEn)
    else $error("jump did not take a second cycle");
  jump_target_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && isJump |=> program_counter == {$past(statusIn[7:5]), $past(instr[8:0])})
    else $error("jump target wrong");
  inc_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && isInc |=> statusWrEn && statusOut[2] == ($past(fileData) == 8'hFF))
    else $error("increment zero flag wrong");
  dest_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && (isInc || isOrReg) |=> fileWrEn == $past(destFile))
    else $error("destination select wrong");
  skip_no_flags_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && isIncSkip |=> !statusWrEn)
    else $error("increment-skip changed flags");
  skip_flush_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && isIncSkip && fileData == 8'hFF |=> flushFetch ##1 !flushFetch)
    else $error("skip did not discard prefetched word");
  or_literal_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && isOrLit |=> accumulator == ($past(accumulator) | $past(instr[7:0])))
    else $error("literal OR result wrong");
  or_reg_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && isOrReg && destFile |=> fileWrData == ($past(accumulator) | $past(fileData)))
    else $error("register OR result wrong");
  // carry flags checked one by one, so a broken carry chain cannot hide behind the zero flag
  inc_carry_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && isInc |=>
      statusOut[branch_inc_or_pkg::ST_CARRY] == ($past(fileData) == 8'hFF) &&
      statusOut[branch_inc_or_pkg::ST_DIGIT] == ($past(fileData[3:0]) == 4'hF))
    else $error("increment carry flags wrong");
  skip_dest_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && isIncSkip |=>
      fileWrEn == $past(destFile) && fileWrData == $past(fileData) + 8'h01)
    else $error("increment-skip result or destination wrong");
  // the discarded slot may only step the counter, nothing else
  flush_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == FLUSH |=> !fileWrEn && !statusWrEn && !flushFetch
      && accumulator == $past(accumulator))
    else $error("discarded slot changed state");
  flush_advance_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == FLUSH |=> program_counter == $past(program_counter) + 12'h001)
    else $error("counter did not step past discarded word");
  or_lit_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    phase == EXEC && isOrLit |=> statusWrEn
      && statusOut[branch_inc_or_pkg::ST_ZERO] == (accumulator == 8'h00))
    else $error("literal OR zero flag wrong");

endmodule

// ===== core/branch_inc_or_pkg.sv
// Purpose: shared constants for the jump / increment / OR execution slice
// Assumes: 12-bit instruction word, 8-bit data path, 12-bit program counter
// Notes: opcode match values are compared against masked instruction bits
package branch_inc_or_pkg;
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int COUNTER_W = 12;
  localparam int ADDR_W = 5;
  // opcode fields
  localparam logic [2:0] OP_JUMP = 3'h5;        // top three bits 101
  localparam logic [5:0] OP_INC = 6'h0A;        // 0010 10
  localparam logic [5:0] OP_INC_SKIP = 6'h0F;   // 0011 11
  localparam logic [5:0] OP_OR_REG = 6'h04;     // 0001 00
  localparam logic [3:0] OP_OR_LIT = 4'hD;      // 1101
  localparam int DEST_BIT = 5;
  localparam int JUMP_K_W = 9;
  // status register bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PAGE_LO = 5;
  localparam int ST_PAGE_HI = 7;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
  localparam logic [COUNTER_W-1:0] COUNTER_RESET = 12'hFFF;
  localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;
endpackage

// ===== tb/file_reg_model.sv
// Purpose: register file and status holder on the far side of the execution slice
// Assumes: reads are combinational on the address field of the current word
// Notes: cells start at 00; the bench presets cells and status by hierarchy
`timescale 1ns/100ps
module file_reg_model (
  input wire logic mclk,
  input wire logic [4:0] rdAddr,
  input wire logic [4:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic [7:0] statusNew,
  input wire logic statusWrEn,
  output logic [7:0] rdData,
  output logic [7:0] status
);
  logic [7:0] mem [32];
  // read path follows the address at once, as the slice expects
  assign rdData = mem[rdAddr];
  // writes land on the edge that shows the strobe, never earlier
  always @(posedge mclk) begin
    if (wrEn)
      mem[wrAddr] <= wrData;
    if (statusWrEn)
      status <= statusNew;
  end
  initial begin
    foreach (mem[i])
      mem[i] = 8'h00;
    status = 8'h00;
  end
endmodule

// ===== tb/tb_branch_inc_or_exec.sv
// Purpose: self-checking bench for the jump, increment and OR slice
// Assumes: one word per cycle, answers one edge later
// Notes: all waits are fixed edge counts, so no bounded loop is needed
`timescale 1ns/100ps
module tb_branch_inc_or_exec;
  logic mclk, rst_n, fileWrEn, statusWrEn, flush;
  logic [11:0] instr, programCounter;
  logic [7:0] fileData, statusIn, fileWrData, acc, statusOut;
  logic [4:0] fileAddr;
  int bad_count = 0;
  int total_checks = 0;
  branch_inc_or_exec DUT (.mclk(mclk), .rst_n(rst_n), .instr(instr), .fileData(fileData),
    .statusIn(statusIn), .fileAddr(fileAddr), .fileWrData(fileWrData), .fileWrEn(fileWrEn),
    .accumulator(acc), .statusOut(statusOut), .statusWrEn(statusWrEn),
    .program_counter(programCounter), .flushFetch(flush));
  file_reg_model model (.mclk(mclk), .rdAddr(instr[4:0]), .wrAddr(fileAddr),
    .wrData(fileWrData), .wrEn(fileWrEn), .statusNew(statusOut),
    .statusWrEn(statusWrEn), .rdData(fileData), .status(statusIn));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chkVal(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkCount(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // present one word, then look just after the answering edge
  task automatic step(input logic [11:0] w);
    instr = w;
    @(posedge mclk);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tJump();
    model.status = 8'h47;
    step(12'hBC3);
    chkCount(programCounter, 12'h5C3);
    chkBit(flush, 1'b1);
    chkBit(statusWrEn, 1'b0);
    step({6'h0A, 1'b1, 5'h03});
    chkBit(fileWrEn, 1'b0);
    chkBit(flush, 1'b0);
    chkCount(programCounter, 12'h5C4);
    $display("test jump done");
  endtask
  task automatic tInc();
    model.mem[3] = 8'hFF;
    model.status = 8'h40;
    step({6'h0A, 1'b1, 5'h03});
    chkVal(fileWrData, 8'h00);
    chkVal({3'h0, fileAddr}, 8'h03);
    chkBit(fileWrEn, 1'b1);
    chkVal(statusOut, 8'h47);
    model.mem[4] = 8'h0F;
    model.status = 8'h40;
    step({6'h0A, 1'b0, 5'h04});
    chkVal(acc, 8'h10);
    chkBit(fileWrEn, 1'b0);
    chkVal(statusOut, 8'h42);
    $display("test increment done");
  endtask
  task automatic tSkip();
    // let the status write of the last increment land before presetting
    step(12'h000);
    model.status = 8'h45;
    model.mem[5] = 8'hFE;
    step({6'h0F, 1'b0, 5'h05});
    chkVal(acc, 8'hFF);
    chkBit(flush, 1'b0);
    model.mem[6] = 8'hFF;
    step({6'h0F, 1'b1, 5'h06});
    chkVal(fileWrData, 8'h00);
    chkBit(flush, 1'b1);
    step({6'h0A, 1'b0, 5'h06});
    chkVal(acc, 8'hFF);
    chkBit(fileWrEn, 1'b0);
    chkVal(statusIn, 8'h45);
    $display("test skip done");
  endtask
  task automatic tOr();
    model.mem[7] = 8'hFF;
    step({6'h0A, 1'b0, 5'h07});
    // status writes lag one edge, so a no-op keeps the preset from being overwritten
    step(12'h000);
    model.status = 8'h40;
    step(12'hD00);
    chkVal(acc, 8'h00);
    chkVal(statusOut, 8'h44);
    step(12'hD5A);
    chkVal(acc, 8'h5A);
    chkVal(statusOut, 8'h40);
    model.mem[8] = 8'hA1;
    model.status = 8'h43;
    step({6'h04, 1'b1, 5'h08});
    chkVal(fileWrData, 8'hFB);
    chkVal(statusOut, 8'h43);
    step({6'h04, 1'b0, 5'h08});
    chkVal(acc, 8'hFB);
    $display("test or done");
  endtask
  initial begin
    rst_n = 1'b0;
    instr = 12'h000;
    repeat (20) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    chkVal(acc, 8'h00);
    chkCount(programCounter, 12'hFFF);
    tJump();
    tInc();
    tSkip();
    tOr();
    final_report();
  end
endmodule
